// >>> logic/ppsc_defs.vh
// Constants for the pad pull and slew configuration register bank.
`ifndef PPSC_DEFS_VH
`define PPSC_DEFS_VH
`define PPSC_OFS_PULL_P3D     8'h8c
`define PPSC_OFS_SLEW_P1A     8'h90
`define PPSC_OFS_SLEW_P1B     8'h94
`define PPSC_ADDR_W           8
`define PPSC_HALF_W           16
`define PPSC_MASK_LSB         16
`define PPSC_SLEW_W           8
`define PPSC_PULL_RESET       16'h00aa
`define PPSC_SLEW_RESET       8'h00
`define PPSC_PULL_Z           2'b00
`define PPSC_PULL_UP          2'b01
`define PPSC_PULL_DOWN        2'b10
`define PPSC_PULL_KEEP        2'b11
`define PPSC_HTRANS_NONSEQ    2'b10
`define PPSC_HSIZE_WORD       3'b010
`define PPSC_HRESP_OKAY       1'b0
`endif

// >>> logic/ppsc_masked_reg.v
// One configuration register whose low half is written under the mask in the high half.
`timescale 1ns/1ns
`default_nettype none
`include "ppsc_defs.vh"
module ppsc_masked_reg #(
  parameter             WIDTH     = 16,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire                    mclk,
  input  wire                    reset,
  input  wire                    wr_en,
  input  wire [31:0]             wr_data,
  output reg  [WIDTH-1:0]        value_reg
);
  wire [WIDTH-1:0] mask;
  wire [WIDTH-1:0] value_next;

  // Bits above WIDTH are never stored, so their writes vanish.
  assign mask       = wr_data[`PPSC_MASK_LSB +: WIDTH];
  // Each low bit takes the written value only where its enable bit is one.
  assign value_next = (value_reg & ~mask) | (wr_data[WIDTH-1:0] & mask);

  always @(posedge mclk) begin
    if (reset) begin
      value_reg <= RESET_VAL;
    end else if (wr_en) begin
      value_reg <= value_next;
    end
  end
endmodule
`default_nettype wire

// >>> logic/ppsc_pad_cfg.v
// AHB-Lite slave holding the pad pull and slew configuration registers.
`timescale 1ns/1ns
`default_nettype none
`include "ppsc_defs.vh"
// Notes on behaviour
// - A write changes low bit n only where written bit n+16 is one.
// - A zero enable bit keeps the stored bit whatever data it carries.
// - Slew low byte bit k sets pin k speed: zero slow, one fast.
// - Slew bits 15 to 8 read zero and ignore writes.
// - Pull pin k uses bits 2k+1:2k: Z, pull-up, pull-down, keeper.
module ppsc_pad_cfg (
  input  wire        mclk,
  input  wire        reset,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [15:0] port3_d_pull,
  output reg  [7:0]  port1_a_slew,
  output reg  [7:0]  port1_b_slew
);
  // Address phase captured for the data phase that follows.
  reg                     wr_pend_reg;
  reg [`PPSC_ADDR_W-1:0]  wr_addr_reg;
  reg [31:0]              rd_next;
  reg [15:0]              pull_rd;
  reg [15:0]              slew_a_rd;
  reg [15:0]              slew_b_rd;
  wire                    take;
  wire [15:0]             pull_q;
  wire [7:0]              slew_a_q;
  wire [7:0]              slew_b_q;

  // Only word-sized transfers are acted on; others complete OKAY with no effect.
  assign take = hsel && hready && htrans[1] && (hsize == `PPSC_HSIZE_WORD);

  function sel_hit;
    input [`PPSC_ADDR_W-1:0] a;
    input [`PPSC_ADDR_W-1:0] ofs;
    begin
      sel_hit = (a == ofs);
    end
  endfunction

  // Value a register holds once a pending masked write has landed.
  function [15:0] fwd_merge;
    input [15:0] old_val;
    input [31:0] wdata;
    begin
      fwd_merge = (old_val & ~wdata[`PPSC_MASK_LSB +: `PPSC_HALF_W]) |
                  (wdata[`PPSC_HALF_W-1:0] & wdata[`PPSC_MASK_LSB +: `PPSC_HALF_W]);
    end
  endfunction

  always @(posedge mclk) begin
    if (reset) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= {`PPSC_ADDR_W{1'b0}};
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= `PPSC_HRESP_OKAY;
    end else begin
      wr_pend_reg <= take && hwrite;
      wr_addr_reg <= haddr[`PPSC_ADDR_W-1:0];
      hreadyout   <= 1'b1;
      hresp       <= `PPSC_HRESP_OKAY;
      if (take && !hwrite) begin
        hrdata <= rd_next;
      end
    end
  end

  // The write mask half reads back as zero; unmapped words read zero.
  // A write whose data phase ends on a read's address edge is merged in, so the read never returns stale data.
  always @* begin
    pull_rd   = pull_q;
    slew_a_rd = {8'h00, slew_a_q};
    slew_b_rd = {8'h00, slew_b_q};
    if (wr_pend_reg && sel_hit(wr_addr_reg, `PPSC_OFS_PULL_P3D)) begin
      pull_rd = fwd_merge(pull_q, hwdata);
    end
    if (wr_pend_reg && sel_hit(wr_addr_reg, `PPSC_OFS_SLEW_P1A)) begin
      slew_a_rd = fwd_merge({8'h00, slew_a_q}, hwdata);
    end
    if (wr_pend_reg && sel_hit(wr_addr_reg, `PPSC_OFS_SLEW_P1B)) begin
      slew_b_rd = fwd_merge({8'h00, slew_b_q}, hwdata);
    end
    rd_next = 32'h0000_0000;
    if (sel_hit(haddr[`PPSC_ADDR_W-1:0], `PPSC_OFS_PULL_P3D)) begin
      rd_next = {16'h0000, pull_rd};
    end else if (sel_hit(haddr[`PPSC_ADDR_W-1:0], `PPSC_OFS_SLEW_P1A)) begin
      rd_next = {24'h00_0000, slew_a_rd[`PPSC_SLEW_W-1:0]};
    end else if (sel_hit(haddr[`PPSC_ADDR_W-1:0], `PPSC_OFS_SLEW_P1B)) begin
      rd_next = {24'h00_0000, slew_b_rd[`PPSC_SLEW_W-1:0]};
    end
  end

  ppsc_masked_reg #(.WIDTH(`PPSC_HALF_W), .RESET_VAL(`PPSC_PULL_RESET)) u_pull (
    .mclk      (mclk),
    .reset     (reset),
    .wr_en     (wr_pend_reg && sel_hit(wr_addr_reg, `PPSC_OFS_PULL_P3D)),
    .wr_data   (hwdata),
    .value_reg (pull_q)
  );

  ppsc_masked_reg #(.WIDTH(`PPSC_SLEW_W), .RESET_VAL(`PPSC_SLEW_RESET)) u_slew_a (
    .mclk      (mclk),
    .reset     (reset),
    .wr_en     (wr_pend_reg && sel_hit(wr_addr_reg, `PPSC_OFS_SLEW_P1A)),
    .wr_data   (hwdata),
    .value_reg (slew_a_q)
  );

  ppsc_masked_reg #(.WIDTH(`PPSC_SLEW_W), .RESET_VAL(`PPSC_SLEW_RESET)) u_slew_b (
    .mclk      (mclk),
    .reset     (reset),
    .wr_en     (wr_pend_reg && sel_hit(wr_addr_reg, `PPSC_OFS_SLEW_P1B)),
    .wr_data   (hwdata),
    .value_reg (slew_b_q)
  );

  // Pad outputs are retimed so they come straight from flip-flops; they lag the register by one cycle.
  always @(posedge mclk) begin
    if (reset) begin
      port3_d_pull <= `PPSC_PULL_RESET;
      port1_a_slew <= `PPSC_SLEW_RESET;
      port1_b_slew <= `PPSC_SLEW_RESET;
    end else begin
      port3_d_pull <= pull_q;
      port1_a_slew <= slew_a_q;
      port1_b_slew <= slew_b_q;
    end
  end
endmodule
`default_nettype wire

// >>> verif/ppsc_pad_cfg_asserts.sv
// Checker for the pad pull and slew register bank.
`timescale 1ns/1ns
`default_nettype none
module ppsc_asserts (
  input wire logic        mclk, reset, hsel, hwrite, hready,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [1:0]  htrans,
  input wire logic [2:0]  hsize,
  input wire logic [15:0] port3_d_pull,
  input wire logic [7:0]  port1_a_slew, port1_b_slew
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic       tk, wa;
  logic [7:0] a;
  assign tk = hsel && hready && htrans[1] && hsize == 3'b010;
  // The pad outputs lag the data phase by one edge, so the write checks look two edges on from wa.
  always @(posedge mclk) begin
    wa <= !reset && tk && hwrite;
    a  <= haddr[7:0];
  end
  // The register lands at the data-phase edge and the pad one edge after it, seen at the edge after that, hence the two-cycle delays.
  property p_pull_set; wa && a == 8'h8c |-> ##2 (port3_d_pull & $past(hwdata[31:16], 2)) ==
    ($past(hwdata[15:0], 2) & $past(hwdata[31:16], 2)); endproperty
  property p_slew_keep; wa && a == 8'h94 |-> ##2
    ((port1_b_slew ^ $past(port1_b_slew)) & ~$past(hwdata[23:16], 2)) == 8'h00; endproperty
  property p_slew_read; tk && !hwrite && haddr[7:0] == 8'h90 |-> ##2 $past(hrdata[7:0]) == port1_a_slew;
  endproperty
  property p_rsvd; tk && !hwrite && haddr[7:0] == 8'h94 |=> hrdata[31:8] == 24'h00_0000; endproperty
  property p_pull_read; tk && !hwrite && haddr[7:0] == 8'h8c |-> ##2 $past(hrdata) == {16'h0000, port3_d_pull};
  endproperty
  property p_init; disable iff (1'b0) reset ##1 reset |=> port3_d_pull == 16'h00aa &&
    port1_a_slew == 8'h00 && port1_b_slew == 8'h00; endproperty
  a_pull_set: assert property (p_pull_set) else $error("pull write");
  a_slew_keep: assert property (p_slew_keep) else $error("slew kept");
  a_slew_read: assert property (p_slew_read) else $error("slew read");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits");
  a_pull_read: assert property (p_pull_read) else $error("pull read");
  a_init: assert property (p_init) else $error("reset value");
  c_wr: cover property (wa && a == 8'h94);
  c_rd: cover property (tk && !hwrite);
  c_rst: cover property (reset ##1 !reset);
endmodule
bind ppsc_pad_cfg ppsc_asserts u_chk (.mclk(mclk), .reset(reset), .hsel(hsel), .hwrite(hwrite), .hready(hready),
  .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata), .htrans(htrans), .hsize(hsize), .port3_d_pull(port3_d_pull),
  .port1_a_slew(port1_a_slew), .port1_b_slew(port1_b_slew));
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the pad pull and slew register bank.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        mclk = 0, reset = 1, hsel = 0, hwrite = 0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 0, hwdata = 0, r, w;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp;
  wire  [15:0] pull;
  wire  [7:0]  sa, sb;
  integer      n_fail = 0, n_tests = 0, seed = 32'h0779, i, k, msk;
  // Index 3 is an unmapped address: it reads zero and keeps nothing.
  logic [7:0]  adr [4] = '{8'h8c, 8'h90, 8'h94, 8'h98};
  int          keep [4] = '{'hffff, 'h00ff, 'h00ff, 0};
  int          m [4] = '{'h00aa, 0, 0, 0};
  ppsc_pad_cfg dut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .port3_d_pull(pull), .port1_a_slew(sa), .port1_b_slew(sb));
  initial forever #5 mclk = ~mclk;
  task xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1; htrans <= 2'b10; haddr <= {24'h00_0000, a}; hwrite <= wr;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    r = hrdata;
  endtask
  task chk(input logic [31:0] got, input int exp);
    n_tests++;
    if (got !== exp[31:0]) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 0;
    for (i = 0; i < 80; i++) begin
      k = $unsigned($random(seed)) % 4;
      w = $random(seed);
      // A reset in mid-run must bring every register back to its reset value.
      if (i == 40) begin
        reset <= 1;
        repeat (2) @(posedge mclk);
        reset <= 0;
        m[0] = 'h00aa;
        m[1] = 0;
        m[2] = 0;
      end
      if (i >= 4) begin
        // The write of every ninth iteration is byte sized, which the block completes but ignores.
        hsize <= (i % 9 == 0) ? 3'b000 : 3'b010;
        xfer(adr[k], 1'b1, w);
        hsize <= 3'b010;
        msk = (i % 9 == 0) ? 0 : w[31:16] & keep[k];
        m[k] = (m[k] & ~msk) | (w & msk);
      end
      xfer(adr[k], 1'b0, 32'h0000_0000);
      chk(r, m[k]);
      chk({sb, sa, pull}, {m[2][7:0], m[1][7:0], m[0][15:0]});
      chk({31'h0000_0000, hresp}, 0);
    end
    end_of_test;
  end
  // Eighty iterations, 76 of them with a write, take about 474 cycles; this leaves ample margin.
  initial begin
    #30000;
    n_fail++;
    end_of_test;
  end
endmodule
`default_nettype wire
